/* File: src/dsmc_ctrl.sv */
// Summary of operation
// - after reset report 0x000, then move unprompted to no-fault 0x250
// - an error during initialization goes straight to stop-at-fault
// - command 0x06 in no-fault enters servo ready, code 0x231
// - command 0x07 in servo ready enters wait-for-servo-on, code 0x233
// - command 0x0F in wait-for-servo-on enters running, code 0x237
// - 0x07 from running to wait-on; 0x06 from running or wait-on to ready
// - 0x00 from ready, wait-on or running returns to no-fault
// - 0x02 in running enters quick stop, code 0x217
// - quick stop option 0..3 falls back to no-fault after stopping
// - option 4..7 holds in quick stop; 0x0F then resumes running
// - a fault in any state but fault enters stop-at-fault, code 0x21F
// - stop-at-fault advances to fault, code 0x218, once stopped
// - rising edge of command bit 7 takes fault back to no-fault
// - while bit 7 stays high all other state commands are ignored
// - status bits 10, 11 and 13..15 are mode bits, bit 14 always zero; bit 12 is the set-point ack
// - falling edge of bit 4 clears status bit 12 when state allows
// - rising edge of bit 4 requests a new set-point when state allows
// - bit 5 picks immediate or deferred set-point update
// - bit 6 picks absolute or relative target position
// - update mode and type latch at acceptance and hold during the move
module dsmc_ctrl
    import dsmc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic [15:0] drive_state_word,
    input wire logic [2:0] quick_stop_option_code,
    input wire dsmc_pkg::dsmc_motion_t motion,
    output dsmc_pkg::dsmc_setpoint_t setpoint,
    output logic power_enable,
    output logic quick_stop_active
);
    import dsmc_pkg::*;

    logic [15:0] drive_command_word_r;
    dsmc_state_t state_r;
    dsmc_state_t state_nxt;
    logic [9:0] code_nxt;
    logic [9:0] code_r;
    logic sp_ack_r;
    logic new_sp_r;
    logic immediate_r;
    logic relative_r;
    logic busy_r;
    logic fault_rst_rise;
    logic sp_rise;
    logic sp_fall;
    logic hold_cmds;
    logic [7:0] cmd_low;
    logic sp_allowed;
    logic [MODE_BITS_W-1:0] mode_bits_r;
    logic req_disable;
    logic req_quick_stop;
    logic req_shutdown;
    logic req_switch_on;
    logic req_enable_op;
    logic sp_take;
    logic power_enable_r;
    logic quick_stop_active_r;

    // command word register, written by the fieldbus stack
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            drive_command_word_r <= CMD_RESET_VAL;
        end else if (cmd_wr) begin
            drive_command_word_r <= cmd_wdata;
        end
    end

    assign cmd_rdata = drive_command_word_r;

    // edge detection on the fault reset bit
    dsmc_edge u_fault_rst_edge (
        .mclk(mclk),
        .rst_b(rst_b),
        .lvl(drive_command_word_r[CMD_BIT_FAULT_RST]),
        .rise(fault_rst_rise),
        .fall()
    );

    // edge detection on the new set-point bit
    dsmc_edge u_sp_edge (
        .mclk(mclk),
        .rst_b(rst_b),
        .lvl(drive_command_word_r[CMD_BIT_NEW_SP]),
        .rise(sp_rise),
        .fall(sp_fall)
    );

    // bit 7 held high masks every other state command
    assign hold_cmds = drive_command_word_r[CMD_BIT_FAULT_RST];
    // bit 4..6 are set-point controls, not part of the state command
    assign cmd_low = drive_command_word_r[7:0] & CMD_LOW_MASK
                     & ~(8'h70);

    // one request per state command; the hold gate sits here once so no branch can miss it
    assign req_disable = !hold_cmds && (cmd_low == CMD_DISABLE);
    assign req_quick_stop = !hold_cmds && (cmd_low == CMD_QUICK_STOP);
    assign req_shutdown = !hold_cmds && (cmd_low == CMD_SHUTDOWN);
    assign req_switch_on = !hold_cmds && (cmd_low == CMD_SWITCH_ON);
    assign req_enable_op = !hold_cmds && (cmd_low == CMD_ENABLE_OP);

    // next-state decode; unmatched commands fall through to hold
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DSMC_INIT: begin
                if (motion.init_error || motion.fault) begin
                    state_nxt = DSMC_FAULT_STOP;
                end else if (motion.init_done) begin
                    state_nxt = DSMC_NO_FAULT;
                end
            end
            DSMC_NO_FAULT: begin
                if (motion.fault) begin
                    state_nxt = DSMC_FAULT_STOP;
                end else if (req_shutdown) begin
                    state_nxt = DSMC_READY;
                end
            end
            DSMC_READY: begin
                if (motion.fault) begin
                    state_nxt = DSMC_FAULT_STOP;
                end else if (req_switch_on) begin
                    state_nxt = DSMC_WAIT_ON;
                end else if (req_disable) begin
                    state_nxt = DSMC_NO_FAULT;
                end
            end
            DSMC_WAIT_ON: begin
                if (motion.fault) begin
                    state_nxt = DSMC_FAULT_STOP;
                end else if (req_enable_op) begin
                    state_nxt = DSMC_RUNNING;
                end else if (req_shutdown) begin
                    state_nxt = DSMC_READY;
                end else if (req_disable) begin
                    state_nxt = DSMC_NO_FAULT;
                end
            end
            DSMC_RUNNING: begin
                if (motion.fault) begin
                    state_nxt = DSMC_FAULT_STOP;
                end else if (req_switch_on) begin
                    state_nxt = DSMC_WAIT_ON;
                end else if (req_shutdown) begin
                    state_nxt = DSMC_READY;
                end else if (req_disable) begin
                    state_nxt = DSMC_NO_FAULT;
                end else if (req_quick_stop) begin
                    state_nxt = DSMC_QUICK_STOP;
                end
            end
            DSMC_QUICK_STOP: begin
                if (motion.fault) begin
                    state_nxt = DSMC_FAULT_STOP;
                end else if (quick_stop_option_code <= QS_OPT_FALLBACK_MAX) begin
                    if (motion.stop_done) begin
                        state_nxt = DSMC_NO_FAULT;
                    end
                end else if (motion.stop_done && req_enable_op) begin
                    state_nxt = DSMC_RUNNING;
                end
            end
            DSMC_FAULT_STOP: begin
                if (motion.stop_done) begin
                    state_nxt = DSMC_FAULT;
                end
            end
            DSMC_FAULT: begin
                if (fault_rst_rise && !motion.fault) begin
                    state_nxt = DSMC_NO_FAULT;
                end
            end
            default: begin
                state_nxt = DSMC_FAULT_STOP; // illegal one-hot code, treat as fault
            end
        endcase
    end

    // state code for the next state, so the code moves with the state
    always_comb begin
        unique case (state_nxt)
            DSMC_INIT: code_nxt = CODE_INIT;
            DSMC_NO_FAULT: code_nxt = CODE_NO_FAULT;
            DSMC_READY: code_nxt = CODE_READY;
            DSMC_WAIT_ON: code_nxt = CODE_WAIT_ON;
            DSMC_RUNNING: code_nxt = CODE_RUNNING;
            DSMC_QUICK_STOP: code_nxt = CODE_QUICK_STOP;
            DSMC_FAULT_STOP: code_nxt = CODE_FAULT_STOP;
            DSMC_FAULT: code_nxt = CODE_FAULT;
            default: code_nxt = CODE_FAULT_STOP;
        endcase
    end

    // state register and its reported code
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r <= DSMC_INIT;
            code_r <= CODE_INIT;
        end else begin
            state_r <= state_nxt;
            code_r <= code_nxt;
        end
    end

    // set-points are only taken while running and not mid-transition
    assign sp_allowed = (state_r == DSMC_RUNNING) && (state_nxt == DSMC_RUNNING);

    // a set-point is taken on a bit 4 rise; in deferred mode a busy move refuses it
    assign sp_take = sp_rise && sp_allowed && (!busy_r || immediate_r);

    // new set-point pulse, one cycle for each accepted rise
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            new_sp_r <= 1'b0;
        end else begin
            new_sp_r <= sp_take;
        end
    end

    // mode and type latch only with no move running, so a running move keeps its attributes
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            immediate_r <= 1'b0;
            relative_r <= 1'b0;
        end else if (sp_take && !busy_r) begin
            immediate_r <= drive_command_word_r[CMD_BIT_IMMEDIATE];
            relative_r <= drive_command_word_r[CMD_BIT_RELATIVE];
        end
    end

    // busy from acceptance until the move ends or the drive leaves running
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
        end else if (sp_take) begin
            busy_r <= 1'b1;
        end else if (motion.move_done || state_r != DSMC_RUNNING) begin
            busy_r <= 1'b0;
        end
    end

    // acknowledge bit 12: set on acceptance, cleared on bit 4 fall when allowed
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sp_ack_r <= 1'b0;
        end else if (sp_take) begin
            sp_ack_r <= 1'b1; // set wins over clear
        end else if (sp_fall && (state_r == DSMC_RUNNING || state_r == DSMC_QUICK_STOP)) begin
            sp_ack_r <= 1'b0;
        end else if (state_r != DSMC_RUNNING && state_r != DSMC_QUICK_STOP) begin
            sp_ack_r <= 1'b0;
        end
    end

    // mode bits come from the mode logic; gated to zero outside running states
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mode_bits_r <= '0;
        end else if (state_r == DSMC_RUNNING || state_r == DSMC_QUICK_STOP) begin
            mode_bits_r <= motion.mode_bits & MODE_BIT14_MASK;
        end else begin
            mode_bits_r <= '0;
        end
    end

    // state word: mode bits over the state code, bit 12 is the set-point ack
    always_comb begin
        drive_state_word = {mode_bits_r, code_r};
        drive_state_word[STAT_BIT_SP_ACK] = sp_ack_r;
    end

    assign setpoint.new_sp = new_sp_r;
    assign setpoint.immediate = immediate_r;
    assign setpoint.relative = relative_r;
    assign setpoint.busy = busy_r;

    // power flag from a flip-flop, decoded from the next state so it moves with the code
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            power_enable_r <= 1'b0;
        end else begin
            power_enable_r <= (state_nxt == DSMC_RUNNING) || (state_nxt == DSMC_QUICK_STOP)
                              || (state_nxt == DSMC_FAULT_STOP);
        end
    end

    // quick stop flag, registered the same way to stay in step with the code
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            quick_stop_active_r <= 1'b0;
        end else begin
            quick_stop_active_r <= (state_nxt == DSMC_QUICK_STOP);
        end
    end

    assign power_enable = power_enable_r;
    assign quick_stop_active = quick_stop_active_r;
endmodule

/* File: src/dsmc_pkg.sv */
package dsmc_pkg;

    // object dictionary index of the command word, as seen by the fieldbus stack
    localparam logic [15:0] CMD_WORD_INDEX = 16'h6040;
    localparam logic [15:0] STATE_WORD_INDEX = 16'h6041;
    localparam logic [15:0] CMD_RESET_VAL = 16'h0000;

    // command word and state word field positions
    localparam int CMD_BIT_NEW_SP = 4;
    localparam int CMD_BIT_IMMEDIATE = 5;
    localparam int CMD_BIT_RELATIVE = 6;
    localparam int CMD_BIT_FAULT_RST = 7;
    localparam int STAT_BIT_SP_ACK = 12;

    // state command values carried in the low byte
    localparam logic [7:0] CMD_DISABLE = 8'h00;
    localparam logic [7:0] CMD_QUICK_STOP = 8'h02;
    localparam logic [7:0] CMD_SHUTDOWN = 8'h06;
    localparam logic [7:0] CMD_SWITCH_ON = 8'h07;
    localparam logic [7:0] CMD_ENABLE_OP = 8'h0f;
    localparam logic [7:0] CMD_LOW_MASK = 8'h7f;

    // state codes reported in bits 0 to 9 of the state word
    localparam logic [9:0] CODE_INIT = 10'h000;
    localparam logic [9:0] CODE_NO_FAULT = 10'h250;
    localparam logic [9:0] CODE_READY = 10'h231;
    localparam logic [9:0] CODE_WAIT_ON = 10'h233;
    localparam logic [9:0] CODE_RUNNING = 10'h237;
    localparam logic [9:0] CODE_QUICK_STOP = 10'h217;
    localparam logic [9:0] CODE_FAULT_STOP = 10'h21f;
    localparam logic [9:0] CODE_FAULT = 10'h218;

    // quick stop option: codes up to this value fall back to no-fault
    localparam logic [2:0] QS_OPT_FALLBACK_MAX = 3'h3;

    // mode-specific status bits
    localparam int MODE_BITS_W = 6;
    localparam logic [MODE_BITS_W-1:0] MODE_BIT14_MASK = 6'h2f; // bit 14 is unused

    typedef enum logic [7:0] {
        DSMC_INIT = 8'b0000_0001,
        DSMC_NO_FAULT = 8'b0000_0010,
        DSMC_READY = 8'b0000_0100,
        DSMC_WAIT_ON = 8'b0000_1000,
        DSMC_RUNNING = 8'b0001_0000,
        DSMC_QUICK_STOP = 8'b0010_0000,
        DSMC_FAULT_STOP = 8'b0100_0000,
        DSMC_FAULT = 8'b1000_0000
    } dsmc_state_t;

    // set-point request presented to the motion profile generator
    typedef struct packed {
        logic new_sp;      // one-cycle pulse, set-point taken
        logic immediate;   // latched update mode
        logic relative;    // latched reference type
        logic busy;        // move in progress, attributes frozen
    } dsmc_setpoint_t;

    // conditions reported by the motion side
    typedef struct packed {
        logic init_done;
        logic init_error;
        logic fault;
        logic stop_done;
        logic move_done;
        logic [MODE_BITS_W-1:0] mode_bits; // status bits 10..15 from the mode logic
    } dsmc_motion_t;

endpackage

/* File: src/dsmc_edge.sv */
// rising and falling edge detector on a same-clock level
module dsmc_edge (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic lvl,
    output logic rise,
    output logic fall
);
    logic lvl_r;

    // previous value starts at zero so a bit already set at reset counts as a rise
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl;
        end
    end

    assign rise = lvl & ~lvl_r;
    assign fall = ~lvl & lvl_r;
endmodule

/* File: bench/dsmc_ctrl_properties.sv */
module dsmc_ctrl_properties
    import dsmc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic [15:0] drive_state_word,
    input wire logic [2:0] quick_stop_option_code,
    input wire dsmc_pkg::dsmc_motion_t motion,
    input wire dsmc_pkg::dsmc_setpoint_t setpoint,
    input wire logic power_enable,
    input wire logic quick_stop_active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] code;
    logic [7:0] cmd_low;
    // bits 4..6 carry set-point attributes, so they never select a state command
    assign code = drive_state_word[9:0];
    assign cmd_low = cmd_rdata[7:0] & 8'h8f;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // fault reset: edge of bit 7 seen while in fault with the cause gone
    sequence s_fault_clear;
        $rose(cmd_rdata[CMD_BIT_FAULT_RST]) ##0 (code == CODE_FAULT && !motion.fault);
    endsequence
    sequence s_bit7_held;
        cmd_rdata[CMD_BIT_FAULT_RST] [*2] ##0 (code == CODE_NO_FAULT && !motion.fault);
    endsequence
    a_init_advance: assert property (code == CODE_INIT && motion.init_done && !motion.init_error
        && !motion.fault |=> code == CODE_NO_FAULT) else $error("init did not advance");
    a_ready_entry: assert property (code == CODE_NO_FAULT && cmd_low == CMD_SHUTDOWN && !motion.fault
        |=> code == CODE_READY) else $error("ready not entered");
    a_wait_entry: assert property (code == CODE_READY && cmd_low == CMD_SWITCH_ON && !motion.fault
        |=> code == CODE_WAIT_ON) else $error("wait-on not entered");
    a_run_entry: assert property (code == CODE_WAIT_ON && cmd_low == CMD_ENABLE_OP && !motion.fault
        |=> code == CODE_RUNNING) else $error("running not entered");
    a_quick_entry: assert property (code == CODE_RUNNING && cmd_low == CMD_QUICK_STOP && !motion.fault
        |=> code == CODE_QUICK_STOP) else $error("quick stop not entered");
    a_fault_entry: assert property (motion.fault && code != CODE_FAULT && code != CODE_FAULT_STOP
        |=> code == CODE_FAULT_STOP) else $error("fault stop not entered");
    a_fault_done: assert property (code == CODE_FAULT_STOP && motion.stop_done |=> code == CODE_FAULT)
        else $error("fault not entered");
    a_fault_reset: assert property (s_fault_clear |-> ##[1:2] code == CODE_NO_FAULT)
        else $error("fault reset ignored");
    a_bit7_hold: assert property (s_bit7_held |=> code == CODE_NO_FAULT)
        else $error("command taken under bit 7");
    a_bit14_zero: assert property (drive_state_word[14] == 1'b0) else $error("bit 14 set");
    a_newsp_pulse: assert property (setpoint.new_sp |-> code == CODE_RUNNING ##1 !setpoint.new_sp)
        else $error("set-point pulse wrong");
    a_ack_clear: assert property ($fell(cmd_rdata[CMD_BIT_NEW_SP]) && code == CODE_RUNNING
        |=> !drive_state_word[STAT_BIT_SP_ACK]) else $error("set-point ack not cleared");
    a_qs_flag: assert property (quick_stop_active == (code == CODE_QUICK_STOP))
        else $error("quick stop flag wrong");
    a_power_stop: assert property (code == CODE_FAULT_STOP |-> power_enable)
        else $error("power off while stopping");
    a_cmd_store: assert property (cmd_wr |=> cmd_rdata == $past(cmd_wdata))
        else $error("command word not stored");
endmodule

bind dsmc_ctrl dsmc_ctrl_properties u_props (.mclk(mclk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .drive_state_word(drive_state_word), .quick_stop_option_code(quick_stop_option_code),
    .motion(motion), .setpoint(setpoint), .power_enable(power_enable), .quick_stop_active(quick_stop_active));

/* File: bench/dsmc_master.sv */
// fieldbus master writing the command word
module dsmc_master (
    input wire logic mclk,
    output logic cmd_wr,
    output logic [15:0] cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_wr = 1'b0;
        cmd_wdata = 16'h0000;
    end
    // one-cycle strobe off the falling edge; the released data lines show the inverted word, not the old word
    task automatic write_word(input logic [15:0] word);
        @(negedge mclk);
        cmd_wr <= 1'b1;
        cmd_wdata <= word;
        @(negedge mclk);
        cmd_wr <= 1'b0;
        cmd_wdata <= ~word;
    endtask
endmodule

/* File: bench/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dsmc_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_wr;
    logic [15:0] cmd_wdata;
    logic [15:0] cmd_rdata;
    logic [15:0] dsw;
    logic [2:0] qs_opt = 3'h0;
    dsmc_motion_t motion = '0;
    dsmc_setpoint_t sp;
    logic pwr;
    logic qs_act;
    int n_errors = 0;
    int check_count = 0;
    // 10 MHz control cycle
    always #50 mclk = ~mclk;
    dsmc_master u_master (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata));
    dsmc_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .drive_state_word(dsw), .quick_stop_option_code(qs_opt), .motion(motion), .setpoint(sp),
        .power_enable(pwr), .quick_stop_active(qs_act));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // four cycles covers the store edge, edge detection and the state update
    task automatic expect_code(input logic [9:0] exp);
        repeat (4) @(negedge mclk);
        check("state code", 16'(exp), 16'(dsw[9:0]));
    endtask
    task automatic step(input logic [15:0] cmd, input logic [9:0] exp);
        u_master.write_word(cmd);
        expect_code(exp);
    endtask
    task automatic go_running();
        step(16'h0006, CODE_READY);
        step(16'h0007, CODE_WAIT_ON);
        step(16'h000f, CODE_RUNNING);
    endtask
    // watchdog sized well above the expected run of about 480 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        $display("unexpected watchdog expiry");
        stop_test();
    end
    initial begin
        repeat (20) @(negedge mclk);
        check("word in reset", 16'h0000, dsw);
        rst_b = 1'b1;
        expect_code(CODE_INIT);
        motion.init_done = 1'b1;
        expect_code(CODE_NO_FAULT);
        step(16'h000f, CODE_NO_FAULT);
        go_running();
        step(16'h0007, CODE_WAIT_ON);
        step(16'h0006, CODE_READY);
        step(16'h0002, CODE_READY);
        step(16'h0000, CODE_NO_FAULT);
        go_running();
        step(16'h0006, CODE_READY);
        step(16'h0007, CODE_WAIT_ON);
        step(16'h0000, CODE_NO_FAULT);
        $display("test transitions done");
        for (int i = 0; i < 8; i++) begin
            // option 4 is held like 5..7
            begin
                go_running();
                qs_opt = 3'(i);
                step(16'h0002, CODE_QUICK_STOP);
                check("quick stop flag", 16'h0001, 16'(qs_act));
                motion.stop_done = 1'b1;
                expect_code(i < 4 ? CODE_NO_FAULT : CODE_QUICK_STOP);
                if (i >= 4) step(16'h000f, CODE_RUNNING);
                motion.stop_done = 1'b0;
                if (i >= 4) step(16'h0000, CODE_NO_FAULT);
            end
        end
        $display("test quick stop done");
        go_running();
        motion.mode_bits = 6'h3f;
        step(16'h003f, CODE_RUNNING);
        check("set-point ack", 16'h0001, 16'(dsw[12]));
        check("mode bits", 16'h002f, 16'(dsw[15:10]));
        check("update mode", 16'h0001, 16'(sp.immediate));
        check("reference type", 16'h0000, 16'(sp.relative));
        check("busy", 16'h0001, 16'(sp.busy));
        step(16'h000f, CODE_RUNNING);
        check("ack cleared", 16'h0000, 16'(dsw[12]));
        step(16'h005f, CODE_RUNNING);
        check("held mode", 16'h0001, 16'(sp.immediate));
        check("held type", 16'h0000, 16'(sp.relative));
        motion.move_done = 1'b1;
        step(16'h000f, CODE_RUNNING);
        motion.move_done = 1'b0;
        step(16'h005f, CODE_RUNNING);
        check("new mode", 16'h0000, 16'(sp.immediate));
        check("new type", 16'h0001, 16'(sp.relative));
        $display("test set-point done");
        motion.fault = 1'b1;
        expect_code(CODE_FAULT_STOP);
        check("power", 16'h0001, 16'(pwr));
        motion.stop_done = 1'b1;
        expect_code(CODE_FAULT);
        motion.fault = 1'b0;
        motion.stop_done = 1'b0;
        step(16'h0006, CODE_FAULT);
        step(16'h0080, CODE_NO_FAULT);
        step(16'h0086, CODE_NO_FAULT);
        step(16'h0006, CODE_READY);
        step(16'h0000, CODE_NO_FAULT);
        $display("test fault done");
        rst_b = 1'b0;
        motion.init_done = 1'b0;
        motion.init_error = 1'b1;
        repeat (2) @(negedge mclk);
        check("word in reset", 16'h0000, dsw);
        rst_b = 1'b1;
        expect_code(CODE_FAULT_STOP);
        $display("test init error done");
        stop_test();
    end
endmodule
